// file: io_line_map.svh
// Purpose: constants for the i/o line sampler (field layout, codes, timing)
// Assumes: 100 MHz clock, 13 general lines, 6 analog channels
// Notes:   the header holds definitions only
// Functional notes
// - line codes: 0 input, 1/7 alternate, 2 analog/pwm, 3 monitored, 4 low, 5 high
// - each digital input has a pull enable and a pull direction bit
// - first record field is the sample set count, always one
// - two-byte digital mask, bits 0..12 map to general lines 0..12
// - one-byte analog mask, bits 0..5 mark analog channels 0..5
// - digital state bytes present only when some digital line is enabled
// - text query gives cr-separated list (code sends the same binary record, tagged DEST_HOST_TEXT), framed query a response frame payload
// - interval zero disables periodic sampling
// - nonzero interval samples every that many milliseconds and transmits
// - periodic samples go to the high/low destination address
// - received samples reach the host only in framed mode, else discarded
// - sleeping device samples while awake, stops when wake hold expires
`ifndef IO_LINE_MAP_SVH
`define IO_LINE_MAP_SVH
`define CFG_UNMONITORED   3'h0
`define CFG_ALT_PIN       3'h1
`define CFG_ANALOG_PWM    3'h2
`define CFG_MONITORED     3'h3
`define CFG_OUT_LOW       3'h4
`define CFG_OUT_HIGH      3'h5
`define CFG_ALT_FUNC      3'h7
`define SAMPLE_SET_COUNT  8'h01
`define CR_BYTE           8'h0d
`define MS_NS             1000000
`define CLK_NS            10
`define CYCLES_PER_MS     (`MS_NS / `CLK_NS)
`endif

// file: io_line_pkg.sv
// Purpose: shared types for the i/o line sampler
// Assumes: nothing beyond the header
// Notes:   byte stream carrier
package io_line_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } stream_byte_s;

  typedef enum logic [1:0] {
    DEST_HOST_TEXT   = 2'h0,
    DEST_HOST_FRAMED = 2'h1,
    DEST_REMOTE      = 2'h2
  } sample_dest_e;
endpackage

// file: byte_fifo.sv
// Purpose: parameterised fifo with valid/ready on both sides
// Assumes: single clock, synchronous reset-free storage
// Notes:   one read per cycle, full and empty are exact
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // pointer and count update
  always_comb begin
    push    = i_in_valid && (cnt_ff != (AW+1)'(DEPTH));
    pop     = i_out_ready && (cnt_ff != '0);
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset, it is only read below the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  assign o_in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem_ff[rd_ff];
endmodule // byte_fifo

// file: io_line_sampler.sv
`include "io_line_map.svh"
// Purpose: configures general lines, builds i/o sample records, streams them out
// Assumes: lines and analog values arrive asynchronously, 100 MHz clock
// Notes:   records leave as bytes through a 16-entry fifo, tagged with a destination
module io_line_sampler #(
  parameter int NLINES   = 13,
  parameter int NANALOG  = 6,
  parameter int MS_COUNT = `CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  // line configuration, 3-bit code per line
  input  wire logic [NLINES*3-1:0]         i_line_cfg,
  input  wire logic [NLINES-1:0]           i_pull_resistor_enable,
  input  wire logic [NLINES-1:0]           i_pull_direction,
  // physical lines
  input  wire logic [NLINES-1:0]           i_line_in,
  output logic      [NLINES-1:0]           o_line_out,
  output logic      [NLINES-1:0]           o_line_oe,
  output logic      [NLINES-1:0]           o_pull_up_en,
  output logic      [NLINES-1:0]           o_pull_down_en,
  // analog values, 16 bits per channel
  input  wire logic [NANALOG*16-1:0]       i_analog_value,
  // settings
  input  wire logic [15:0]                 i_periodic_sample_interval,
  input  wire logic [31:0]                 i_dest_addr_high,
  input  wire logic [31:0]                 i_dest_addr_low,
  input  wire logic                        i_host_framing_mode,
  input  wire logic                        i_awake,
  // immediate query
  input  wire logic                        i_force_sample_query,
  // received sample bytes from the radio side
  input  wire io_line_pkg::stream_byte_s   i_rx_sample,
  input  wire logic                        i_rx_valid,
  output logic                             o_host_rx_valid,
  output io_line_pkg::stream_byte_s        o_host_rx_sample,
  // outgoing record stream
  output logic                             o_rec_valid,
  output io_line_pkg::stream_byte_s        o_rec_byte,
  output io_line_pkg::sample_dest_e        o_rec_dest,
  output logic      [63:0]                 o_rec_dest_addr,
  input  wire logic                        i_rec_ready,
  output logic                             o_busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_EMIT  = 3'h1,
    ST_DONE  = 3'h2
  } build_e;

  // reset release through two flops
  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // two-flop synchronisers for lines and analog values
  logic [NLINES-1:0]    line_meta_ff, line_sync_ff;
  logic [NANALOG*16-1:0] ana_meta_ff, ana_sync_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      line_meta_ff <= '0;
      line_sync_ff <= '0;
      ana_meta_ff  <= '0;
      ana_sync_ff  <= '0;
    end else begin
      line_meta_ff <= i_line_in;
      line_sync_ff <= line_meta_ff;
      ana_meta_ff  <= i_analog_value;
      ana_sync_ff  <= ana_meta_ff;
    end
  end

  function automatic logic [2:0] cfg_of(input logic [NLINES*3-1:0] c, input int i);
    cfg_of = c[i*3 +: 3];
  endfunction

  // per-line decode of the configuration code
  logic [NLINES-1:0] dig_en, nxt_out, nxt_oe, nxt_pu, nxt_pd;
  logic [NANALOG-1:0] ana_en;
  genvar g;
  generate
    for (g = 0; g < NLINES; g++) begin : g_line
      always_comb begin
        dig_en[g]  = (cfg_of(i_line_cfg, g) == `CFG_MONITORED);
        nxt_oe[g]  = (cfg_of(i_line_cfg, g) == `CFG_OUT_LOW) ||
                     (cfg_of(i_line_cfg, g) == `CFG_OUT_HIGH);
        nxt_out[g] = (cfg_of(i_line_cfg, g) == `CFG_OUT_HIGH);
        // pulls act whenever the line is not driven as an output (codes 4 and 5)
        nxt_pu[g]  = !nxt_oe[g] && i_pull_resistor_enable[g] && i_pull_direction[g];
        nxt_pd[g]  = !nxt_oe[g] && i_pull_resistor_enable[g] && !i_pull_direction[g];
      end
    end
    for (g = 0; g < NANALOG; g++) begin : g_ana
      assign ana_en[g] = (cfg_of(i_line_cfg, g) == `CFG_ANALOG_PWM);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_line_out     <= '0;
      o_line_oe      <= '0;
      o_pull_up_en   <= '0;
      o_pull_down_en <= '0;
    end else begin
      o_line_out     <= nxt_out;
      o_line_oe      <= nxt_oe;
      o_pull_up_en   <= nxt_pu;
      o_pull_down_en <= nxt_pd;
    end
  end

  // millisecond enable and interval counter
  logic [31:0] ms_cnt_ff, nxt_ms_cnt;
  logic [15:0] ivl_cnt_ff, nxt_ivl_cnt;
  logic        ms_tick, periodic_req;
  always_comb begin
    ms_tick      = (ms_cnt_ff == 32'(MS_COUNT - 1));
    nxt_ms_cnt   = ms_tick ? '0 : ms_cnt_ff + 32'h1;
    nxt_ivl_cnt  = ivl_cnt_ff;
    periodic_req = 1'b0;
    // zero interval or asleep holds the counter clear
    if (i_periodic_sample_interval == 16'h0 || !i_awake) begin
      nxt_ivl_cnt = '0;
    end else if (ms_tick) begin
      if (ivl_cnt_ff + 16'h1 >= i_periodic_sample_interval) begin
        nxt_ivl_cnt  = '0;
        periodic_req = 1'b1;
      end else begin
        nxt_ivl_cnt = ivl_cnt_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ms_cnt_ff  <= '0;
      ivl_cnt_ff <= '0;
    end else begin
      ms_cnt_ff  <= nxt_ms_cnt;
      ivl_cnt_ff <= nxt_ivl_cnt;
    end
  end

  // record builder: byte list snapshotted at start, emitted into the fifo
  localparam int MAXB = 4 + 2 + 2 * NANALOG;
  build_e         st_ff, nxt_st;
  logic [7:0]     buf_ff [MAXB];
  logic [7:0]     nxt_buf [MAXB];
  logic [4:0]     len_ff, nxt_len, idx_ff, nxt_idx;
  io_line_pkg::sample_dest_e dest_ff, nxt_dest;
  logic           pend_q_ff, nxt_pend_q, pend_p_ff, nxt_pend_p;
  logic           fifo_in_ready;
  logic           push;
  io_line_pkg::stream_byte_s push_byte;
  logic [15:0]    dmask, dstate;

  always_comb begin
    nxt_st     = st_ff;
    nxt_len    = len_ff;
    nxt_idx    = idx_ff;
    nxt_dest   = dest_ff;
    nxt_buf    = buf_ff;
    // requests arriving while busy are held, a set in the starting cycle is served by that record unless a query takes that record
    nxt_pend_q = pend_q_ff || i_force_sample_query;
    nxt_pend_p = pend_p_ff || periodic_req;
    push       = 1'b0;
    push_byte  = '0;
    dmask      = 16'(dig_en);
    dstate     = 16'(line_sync_ff & dig_en);
    case (st_ff)
      ST_IDLE: begin
        if (nxt_pend_q || nxt_pend_p) begin
          // query has priority over the periodic sample
          if (nxt_pend_q) begin
            nxt_dest   = i_host_framing_mode ? io_line_pkg::DEST_HOST_FRAMED
                                             : io_line_pkg::DEST_HOST_TEXT;
            nxt_pend_q = 1'b0;
          end else begin
            nxt_dest   = io_line_pkg::DEST_REMOTE;
            nxt_pend_p = 1'b0;
          end
          nxt_buf[0] = `SAMPLE_SET_COUNT;
          nxt_buf[1] = dmask[15:8];
          nxt_buf[2] = dmask[7:0];
          nxt_buf[3] = 8'(ana_en);
          nxt_len    = 5'h4;
          if (dig_en != '0) begin
            nxt_buf[nxt_len]        = dstate[15:8];
            nxt_buf[nxt_len + 5'h1] = dstate[7:0];
            nxt_len                 = nxt_len + 5'h2;
          end
          for (int a = 0; a < NANALOG; a++) begin
            if (ana_en[a]) begin
              nxt_buf[nxt_len]        = ana_sync_ff[a*16+8 +: 8];
              nxt_buf[nxt_len + 5'h1] = ana_sync_ff[a*16 +: 8];
              nxt_len                 = nxt_len + 5'h2;
            end
          end
          nxt_idx = '0;
          nxt_st  = ST_EMIT;
        end
      end
      ST_EMIT: begin
        // fifo back-pressure stalls the builder
        if (fifo_in_ready) begin
          push           = 1'b1;
          push_byte.data = buf_ff[idx_ff];
          push_byte.last = (idx_ff == len_ff - 5'h1);
          nxt_idx        = idx_ff + 5'h1;
          if (push_byte.last) begin
            nxt_st = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff     <= ST_IDLE;
      len_ff    <= '0;
      idx_ff    <= '0;
      dest_ff   <= io_line_pkg::DEST_HOST_TEXT;
      pend_q_ff <= 1'b0;
      pend_p_ff <= 1'b0;
      for (int i = 0; i < MAXB; i++) begin
        buf_ff[i] <= '0;
      end
    end else begin
      st_ff     <= nxt_st;
      len_ff    <= nxt_len;
      idx_ff    <= nxt_idx;
      dest_ff   <= nxt_dest;
      pend_q_ff <= nxt_pend_q;
      pend_p_ff <= nxt_pend_p;
      buf_ff    <= nxt_buf;
    end
  end

  // fifo in the record path; destination rides with each byte
  logic        fifo_out_valid;
  logic [10:0] fifo_out_data;
  logic        fifo_pop;
  byte_fifo #(
    .WIDTH (11),
    .DEPTH (16)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n_ff),
    .i_in_valid  (push),
    .i_in_data   ({dest_ff, push_byte}),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_pop)
  );

  // output register stage, refilled when empty or taken
  logic out_free;
  assign out_free = !o_rec_valid || i_rec_ready;
  assign fifo_pop = out_free;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_rec_valid     <= 1'b0;
      o_rec_byte      <= '0;
      o_rec_dest      <= io_line_pkg::DEST_HOST_TEXT;
      o_rec_dest_addr <= '0;
      o_busy          <= 1'b0;
    end else begin
      if (out_free) begin
        o_rec_valid <= fifo_out_valid;
        o_rec_byte  <= fifo_out_data[8:0];
        o_rec_dest  <= io_line_pkg::sample_dest_e'(fifo_out_data[10:9]);
      end
      o_rec_dest_addr <= {i_dest_addr_high, i_dest_addr_low};
      o_busy          <= (nxt_st != ST_IDLE);
    end
  end

  // received samples pass to the host only in framed mode
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_host_rx_valid  <= 1'b0;
      o_host_rx_sample <= '0;
    end else begin
      o_host_rx_valid  <= i_rx_valid && i_host_framing_mode;
      o_host_rx_sample <= i_rx_sample;
    end
  end
endmodule // io_line_sampler

// file: io_line_sampler_sva.sv
// Purpose: port assertions for the i/o line sampler
// Assumes: outputs settle within three edges of reset release
// Notes:   line checks watch line 0 only, except pull exclusion over all lines, to keep the checker small
module io_line_sampler_sva #(
  parameter int NLINES   = 13,
  parameter int NANALOG  = 6,
  parameter int MS_COUNT = 100000
) (
  // clock and reset
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  // line setup and drive
  input wire logic [NLINES*3-1:0]       i_line_cfg,
  input wire logic [NLINES-1:0]         i_pull_resistor_enable,
  input wire logic [NLINES-1:0]         i_pull_direction,
  input wire logic [NLINES-1:0]         o_line_out,
  input wire logic [NLINES-1:0]         o_line_oe,
  input wire logic [NLINES-1:0]         o_pull_up_en,
  input wire logic [NLINES-1:0]         o_pull_down_en,
  // settings and streams
  input wire logic [31:0]               i_dest_addr_high,
  input wire logic [31:0]               i_dest_addr_low,
  input wire logic [63:0]               o_rec_dest_addr,
  input wire logic                      i_host_framing_mode,
  input wire io_line_pkg::stream_byte_s i_rx_sample,
  input wire logic                      i_rx_valid,
  input wire logic                      o_host_rx_valid,
  input wire io_line_pkg::stream_byte_s o_host_rx_sample,
  input wire logic                      o_rec_valid,
  input wire io_line_pkg::stream_byte_s o_rec_byte,
  input wire io_line_pkg::sample_dest_e o_rec_dest,
  input wire logic                      i_rec_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic open_ff;
  logic nxt_open;
  // open while a record is part way out, so the next byte is not a first byte
  always_comb begin
    nxt_open = open_ff;
    if (o_rec_valid && i_rec_ready) nxt_open = !o_rec_byte.last;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) open_ff <= 1'b0;
    else open_ff <= nxt_open;
  end
  // long antecedents ride out the two-flop reset release
  out_high_a: assert property ((i_line_cfg[2:0] == 3'h5) [*5] |-> o_line_oe[0] && o_line_out[0])
    else $error("line 0 not driven high");
  out_low_a: assert property ((i_line_cfg[2:0] == 3'h4) [*5] |-> o_line_oe[0] && !o_line_out[0])
    else $error("line 0 not driven low");
  pull_up_a: assert property ((i_line_cfg[2:0] == 3'h0 && i_pull_resistor_enable[0]
    && i_pull_direction[0]) [*5] |-> o_pull_up_en[0] && !o_pull_down_en[0])
    else $error("line 0 pull up missing");
  pull_excl_a: assert property (!(|(o_pull_up_en & o_pull_down_en)))
    else $error("pull up and down together");
  rec_hold_a: assert property (o_rec_valid && !i_rec_ready |=> o_rec_valid
    && $stable(o_rec_byte) && $stable(o_rec_dest))
    else $error("record byte dropped while stalled");
  first_byte_a: assert property (o_rec_valid && !open_ff |-> o_rec_byte.data == 8'h01)
    else $error("record does not open with set count");
  host_fwd_a: assert property (i_rx_valid && i_host_framing_mode |=> o_host_rx_valid
    && o_host_rx_sample == $past(i_rx_sample))
    else $error("received byte not forwarded");
  host_drop_a: assert property (o_host_rx_valid
    |-> $past(i_rx_valid) && $past(i_host_framing_mode))
    else $error("received byte leaked in transparent mode");
  dest_addr_a: assert property ($stable({i_dest_addr_high, i_dest_addr_low}) [*5]
    |-> o_rec_dest_addr == {i_dest_addr_high, i_dest_addr_low})
    else $error("destination address wrong");
  rec_done_c: cover property (o_rec_valid && i_rec_ready && o_rec_byte.last);
  rec_stall_c: cover property (o_rec_valid && !i_rec_ready);
  host_fwd_c: cover property (o_host_rx_valid);
endmodule // io_line_sampler_sva

bind io_line_sampler io_line_sampler_sva #(
  .NLINES(NLINES), .NANALOG(NANALOG), .MS_COUNT(MS_COUNT)) u_sva (.*);

// file: rec_sink.sv
// Purpose: far-side consumer of the record stream
// Assumes: one byte taken per cycle while ready is high
// Notes:   slow pacing stalls every other cycle to exercise the hold
module rec_sink (
  // clock
  input  wire logic                      i_clk,
  // stream from the sampler
  input  wire logic                      i_valid,
  input  wire io_line_pkg::stream_byte_s i_byte,
  input  wire io_line_pkg::sample_dest_e i_dest,
  output logic                           o_ready,
  // pacing
  input  wire logic                      i_slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]                got_q[$];
  int                        rec_cnt = 0;
  io_line_pkg::sample_dest_e last_dest;
  initial o_ready = 1'b0;
  // take bytes on the accepting edge, count whole records on last
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got_q.push_back(i_byte.data);
      last_dest = i_dest;
      if (i_byte.last) rec_cnt++;
    end
    o_ready <= i_slow ? !o_ready : 1'b1;
  end
endmodule // rec_sink

// file: tb_top.sv
// Purpose: self-checking bench for the i/o line sampler
// Assumes: millisecond shortened to 10 cycles
// Notes:   records are collected by the sink model and compared here
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      i_clk = 1'b0;
  logic                      i_reset_n = 1'b0;
  logic [38:0]               i_line_cfg = '0;
  logic [12:0]               i_pull_resistor_enable = '0;
  logic [12:0]               i_pull_direction = '0;
  logic [12:0]               i_line_in = '0;
  logic [95:0]               i_analog_value = '0;
  logic [15:0]               i_periodic_sample_interval = '0;
  logic [31:0]               i_dest_addr_high = '0;
  logic [31:0]               i_dest_addr_low = '0;
  logic                      i_host_framing_mode = 1'b0;
  logic                      i_awake = 1'b1;
  logic                      i_force_sample_query = 1'b0;
  logic                      i_rx_valid = 1'b0;
  logic                      slow = 1'b0;
  io_line_pkg::stream_byte_s i_rx_sample = '0;
  logic [12:0]               o_line_out, o_line_oe, o_pull_up_en, o_pull_down_en;
  logic                      o_host_rx_valid, o_rec_valid, i_rec_ready, o_busy;
  io_line_pkg::stream_byte_s o_host_rx_sample, o_rec_byte;
  io_line_pkg::sample_dest_e o_rec_dest;
  logic [63:0]               o_rec_dest_addr;
  int                        fails = 0;
  int                        checks_done = 0;
  always #5 i_clk = !i_clk;
  io_line_sampler #(.MS_COUNT(10)) u_dut (.*);
  rec_sink u_sink (.i_clk(i_clk), .i_valid(o_rec_valid), .i_byte(o_rec_byte),
    .i_dest(o_rec_dest), .o_ready(i_rec_ready), .i_slow(slow));
  // count one comparison, report it at once if it missed
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic set_cfg(input int c[13]);
    @(posedge i_clk);
    for (int k = 0; k < 13; k++) i_line_cfg[3*k+:3] <= 3'(c[k]);
  endtask
  // wait for one whole record, optionally asking for it, then compare it
  task automatic query(input logic [7:0] e[], input io_line_pkg::sample_dest_e d,
                       input logic trig);
    int n;
    int c0;
    n = 0;
    repeat (4) @(posedge i_clk);
    u_sink.got_q.delete();
    c0 = u_sink.rec_cnt;
    if (trig) begin
      @(posedge i_clk) i_force_sample_query <= 1'b1;
      @(posedge i_clk) i_force_sample_query <= 1'b0;
    end
    while (u_sink.rec_cnt == c0 && n < 3000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    // realign so that later stimulus lands on a rising edge
    @(posedge i_clk);
    chk(n < 3000, "record timeout");
    chk(u_sink.got_q.size() == e.size(), "record length");
    foreach (e[k]) if (k < u_sink.got_q.size()) chk(u_sink.got_q[k] === e[k], "record byte");
    chk(u_sink.last_dest === d, "record destination");
  endtask
  // no record may appear for a while
  task automatic quiet(input int n);
    int c0;
    c0 = u_sink.rec_cnt;
    repeat (n) @(posedge i_clk);
    chk(u_sink.rec_cnt == c0 && o_busy === 1'b0, "unexpected record");
  endtask
  // main sequence
  initial begin
    logic [2:0] cd;
    int n;
    int c0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    i_pull_resistor_enable <= 13'h1fff;
    i_pull_direction <= 13'h0ccd;
    set_cfg('{0, 3, 4, 5, 0, 3, 4, 5, 1, 7, 2, 5, 4});
    repeat (6) @(posedge i_clk);
    for (int k = 0; k < 13; k++) begin
      cd = i_line_cfg[3*k+:3];
      chk(o_line_oe[k] === (cd inside {4, 5}) && o_line_out[k] === (cd == 5), "drive");
      if (cd inside {0, 3}) chk(o_pull_up_en[k] === i_pull_direction[k]
        && o_pull_down_en[k] === !i_pull_direction[k], "pull");
    end
    // text query, mixed lines, stalling sink
    slow <= 1'b1;
    i_line_in <= 13'h0408;
    i_analog_value <= {16'h0, 16'hbeef, 32'h0, 16'h0124, 16'h03d0};
    set_cfg('{2, 2, 3, 3, 0, 0, 0, 0, 0, 0, 3, 3, 0});
    query('{8'h01, 8'h0c, 8'h0c, 8'h03, 8'h04, 8'h08, 8'h03, 8'hd0, 8'h01, 8'h24},
          io_line_pkg::DEST_HOST_TEXT, 1'b1);
    slow <= 1'b0;
    i_host_framing_mode <= 1'b1;
    i_analog_value <= {16'h0c3f, 80'h0};
    set_cfg('{5, 4, 0, 0, 0, 2, 0, 0, 0, 0, 0, 0, 4});
    query('{8'h01, 8'h00, 8'h00, 8'h20, 8'h0c, 8'h3f}, io_line_pkg::DEST_HOST_FRAMED, 1'b1);
    i_line_in <= 13'h1001;
    set_cfg('{3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3});
    query('{8'h01, 8'h1f, 8'hff, 8'h00, 8'h10, 8'h01}, io_line_pkg::DEST_HOST_FRAMED, 1'b1);
    // received bytes pass only in framed mode
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk);
      i_host_framing_mode <= m[0];
      i_rx_valid <= 1'b1;
      i_rx_sample <= '{data: 8'h5a, last: 1'b1};
      @(posedge i_clk);
      i_rx_valid <= 1'b0;
      @(posedge i_clk);
      chk(o_host_rx_valid === m[0], "host forward");
    end
    // periodic records to the remote address, then off by interval and by sleep
    i_host_framing_mode <= 1'b0;
    i_dest_addr_high <= 32'h1234_5678;
    i_dest_addr_low <= 32'h9abc_def0;
    i_periodic_sample_interval <= 16'h0002;
    query('{8'h01, 8'h1f, 8'hff, 8'h00, 8'h10, 8'h01}, io_line_pkg::DEST_REMOTE, 1'b0);
    chk(o_rec_dest_addr === 64'h1234_5678_9abc_def0, "destination address");
    n = 0;
    c0 = u_sink.rec_cnt;
    while (u_sink.rec_cnt == c0 && n < 100) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(n >= 19 && n <= 22, "sample period");
    @(posedge i_clk) i_periodic_sample_interval <= 16'h0000;
    // line 0 driven low while no records are due
    set_cfg('{4, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3});
    repeat (60) @(posedge i_clk);
    quiet(300);
    i_periodic_sample_interval <= 16'h0002;
    i_awake <= 1'b0;
    repeat (60) @(posedge i_clk);
    quiet(300);
    set_cfg('{3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3});
    i_awake <= 1'b1;
    query('{8'h01, 8'h1f, 8'hff, 8'h00, 8'h10, 8'h01}, io_line_pkg::DEST_REMOTE, 1'b0);
    results();
  end
  // watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    #100us;
    fails++;
    results();
  end
endmodule // tb_top
